// File: rtl/pwg_pkg.sv
// pwm generator package: register offsets, field positions, reset values, codes
// assumes a plain address/strobe register port with 16-bit data
package pwg_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [3:0] GEN_CTRL_OFS  = 4'h0;  // generator_control_reg
  localparam logic [3:0] TB_CTRL_OFS   = 4'h1;  // time_base_control_reg
  localparam logic [3:0] TB_CTRL2_OFS  = 4'h2;  // time_base_control2_reg
  localparam logic [3:0] PERIOD_OFS    = 4'h3;  // period value
  localparam logic [3:0] DUTY_OFS      = 4'h4;  // duty_value
  localparam logic [3:0] PHASE_OFS     = 4'h5;  // phase_value
  localparam logic [3:0] DEAD_OFS      = 4'h6;  // dead_time_value
  localparam logic [3:0] FLT_CTRL_OFS  = 4'h7;  // fault_limit_control_reg
  localparam logic [3:0] OUT_CTRL_OFS  = 4'h8;  // output_control_reg
  localparam logic [3:0] IRQ_STAT_OFS  = 4'h9;  // sticky event status
  localparam logic [3:0] IRQ_MASK_OFS  = 4'ha;  // event mask

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int GEN_IMM_BIT   = 0;   // immediate update
  localparam int GEN_CRST_BIT  = 1;   // current-reset mode
  localparam int GEN_ITB_BIT   = 9;   // independent time base
  localparam int TB_EN_BIT     = 15;  // module_on
  localparam int DIV_LSB       = 0;   // pwm_clock_divider [2:0]
  localparam int SRC_LSB       = 10;  // comparator source [14:10]
  localparam int OVERRIDE_PERIOD_SYNC_BIT     = 0;   // override_period_sync
  localparam int OVD_LSB       = 6;   // override_value [7:6]
  localparam int OVRL_BIT      = 8;   // low_side_override_on
  localparam int OVRH_BIT      = 9;   // high_side_override_on
  localparam int MODE_LSB      = 10;  // output mode [11:10]

  // ----------------------------------------
  // codes and reset values
  // ----------------------------------------
  localparam logic [1:0] MODE_PUSHPULL  = 2'h1;
  localparam logic [1:0] MODE_REDUNDANT = 2'h2;
  localparam logic [1:0] OVD_ZERO_DUTY  = 2'h1;  // low on, high off
  localparam logic [1:0] OVD_FULL_DUTY  = 2'h2;  // high on, low off
  localparam logic [15:0] PERIOD_RST    = 16'h00ff;
  localparam logic [15:0] DEAD_RST      = 16'h0004;
  localparam logic [15:0] REG_ZERO      = 16'h0000;
  localparam int NUM_EVENTS             = 4;     // period, climit, ovr release, lost dt

endpackage : pwg_pkg

// File: rtl/pwg_deadtime.sv
// complementary pair shaper: dead time and released-override glitch
// assumes a single clock; the prescale tick comes from the main module
`timescale 1ns/10ps
module pwg_deadtime (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // control
  input  wire logic        tick_i,       // one pwm-clock tick
  input  wire logic        raw_i,        // ideal high-side level
  input  wire logic [15:0] dead_i,       // dead time in ticks
  input  wire logic        skip_dt_i,    // lose dead time on next edge
  input  wire logic        glitch_i,     // one-tick glitch request
  // outputs
  output logic             hi_o,
  output logic             lo_o,
  output logic             lost_o        // pulse: an edge had no dead time
);

  logic        prev;       // last raw level seen
  logic [15:0] cnt;        // dead time remaining
  logic        glitch;     // glitch pending for one tick

  // ----------------------------------------
  // dead time insertion
  // ----------------------------------------
  // both sides off during the count; skip lets the other side rise at once
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      prev   <= 1'b0;
      cnt    <= '0;
      hi_o   <= 1'b0;
      lo_o   <= 1'b0;
      lost_o <= 1'b0;
      glitch <= 1'b0;
    end else begin
      lost_o <= 1'b0;
      if (glitch_i) begin
        glitch <= 1'b1;
      end
      if (tick_i) begin
        prev <= raw_i;
        if (raw_i != prev) begin
          if (skip_dt_i || dead_i == '0) begin
            hi_o   <= raw_i;
            lo_o   <= ~raw_i;
            cnt    <= '0;
            lost_o <= skip_dt_i;
          end else begin
            hi_o <= 1'b0;
            lo_o <= 1'b0;
            cnt  <= dead_i - 16'h0001;
          end
        end else if (cnt != '0) begin
          cnt <= cnt - 16'h0001;
        end else if (glitch) begin
          // released override: both rise for one tick, on the first tick with no edge and no count
          hi_o   <= 1'b1;
          lo_o   <= 1'b1;
          glitch <= 1'b0;
        end else begin
          hi_o <= raw_i;
          lo_o <= ~raw_i;
        end
      end
    end
  end

endmodule // pwg_deadtime

// File: rtl/pwg_core.sv
// complementary pwm generator with current reset, override and dead time
// assumes synchronous inputs, 40 MHz mclk_i, software on the plain register port
`timescale 1ns/10ps
module pwg_core
  import pwg_pkg::*;
#(
  parameter int NCMP = 32                  // comparator inputs
) (
  // clock and reset
  input  wire logic            mclk_i,
  input  wire logic            rst_n_i,
  // register port
  input  wire logic [3:0]      addr_i,
  input  wire logic [15:0]     wdata_i,
  input  wire logic            wr_i,
  input  wire logic            rd_i,
  output logic      [15:0]     rdata_o,
  // pins
  input  wire logic [NCMP-1:0] cmp_i,      // external comparators
  input  wire logic            master_period_i, // master boundary pulse
  output logic                 high_side_output_o,
  output logic                 low_side_output_o,
  output logic                 irq_o
);
  import pwg_pkg::*;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] gen_ctrl, tb_ctrl, tb_ctrl2, period, duty, phase;
  logic [15:0] dead, flt_ctrl, out_ctrl;
  logic [NUM_EVENTS-1:0] irq_stat, irq_mask;
  logic [NUM_EVENTS-1:0] ev;                // event pulses

  // field views
  wire imm_upd   = gen_ctrl[GEN_IMM_BIT];
  wire cur_rst   = gen_ctrl[GEN_CRST_BIT];
  wire itb       = gen_ctrl[GEN_ITB_BIT];
  wire module_on = tb_ctrl[TB_EN_BIT];
  wire [2:0] div = tb_ctrl2[DIV_LSB +: 3];
  wire [4:0] src = flt_ctrl[SRC_LSB +: 5];
  wire override_period_sync     = out_ctrl[OVERRIDE_PERIOD_SYNC_BIT];
  wire [1:0] ovd = out_ctrl[OVD_LSB +: 2];
  wire [1:0] mode = out_ctrl[MODE_LSB +: 2];
  wire ovr_h     = out_ctrl[OVRH_BIT];
  wire ovr_l     = out_ctrl[OVRL_BIT];

  // register write and read, one cycle latency
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      gen_ctrl <= REG_ZERO;
      tb_ctrl  <= REG_ZERO;
      tb_ctrl2 <= REG_ZERO;
      period   <= PERIOD_RST;
      duty     <= REG_ZERO;
      phase    <= REG_ZERO;
      dead     <= DEAD_RST;
      flt_ctrl <= REG_ZERO;
      out_ctrl <= REG_ZERO;
      irq_mask <= '0;
    end else if (wr_i) begin
      case (addr_i)
        GEN_CTRL_OFS: gen_ctrl <= wdata_i;
        TB_CTRL_OFS:  tb_ctrl  <= wdata_i;
        TB_CTRL2_OFS: tb_ctrl2 <= wdata_i;
        PERIOD_OFS:   period   <= wdata_i;
        DUTY_OFS:     duty     <= wdata_i;
        PHASE_OFS:    phase    <= wdata_i;
        DEAD_OFS:     dead     <= wdata_i;
        FLT_CTRL_OFS: flt_ctrl <= wdata_i;
        OUT_CTRL_OFS: out_ctrl <= wdata_i;
        IRQ_MASK_OFS: irq_mask <= wdata_i[NUM_EVENTS-1:0];
        default: ;                             // unmapped: ignored
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_o <= REG_ZERO;
    end else if (rd_i) begin
      case (addr_i)
        GEN_CTRL_OFS: rdata_o <= gen_ctrl;
        TB_CTRL_OFS:  rdata_o <= tb_ctrl;
        TB_CTRL2_OFS: rdata_o <= tb_ctrl2;
        PERIOD_OFS:   rdata_o <= period;
        DUTY_OFS:     rdata_o <= duty;
        PHASE_OFS:    rdata_o <= phase;
        DEAD_OFS:     rdata_o <= dead;
        FLT_CTRL_OFS: rdata_o <= flt_ctrl;
        OUT_CTRL_OFS: rdata_o <= out_ctrl;
        IRQ_STAT_OFS: rdata_o <= {12'h000, irq_stat};
        IRQ_MASK_OFS: rdata_o <= {12'h000, irq_mask};
        default:      rdata_o <= REG_ZERO;
      endcase
    end else begin
      rdata_o <= REG_ZERO;
    end
  end

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  // tick every 2^div clocks; wider div gives coarser resolution
  logic [6:0] pre;
  logic       tick;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pre  <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (pre == 7'h00);
      if (pre >= ((7'h01 << div) - 7'h01)) begin
        pre <= '0;
      end else begin
        pre <= pre + 7'h01;
      end
    end
  end

  // ----------------------------------------
  // time base and current reset
  // ----------------------------------------
  logic [15:0] tmr;
  logic        alt;          // alternate-cycle toggle for itb current reset
  logic        cmp_q;        // selected comparator, delayed for edge
  wire         cmp_sel = cmp_i[src];
  wire         cmp_rise = cmp_sel & ~cmp_q;
  wire         end_cyc = tmr >= period;
  // in itb current-reset mode only every second reset is honoured
  wire         rst_take = cmp_rise & cur_rst & (!itb | alt);

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tmr   <= '0;
      alt   <= 1'b0;
      cmp_q <= 1'b0;
    end else begin
      cmp_q <= cmp_sel;
      if (!module_on) begin
        tmr <= '0;
        alt <= 1'b0;
      end else if (cmp_rise && cur_rst) begin
        alt <= ~alt;
        if (rst_take) begin
          tmr <= '0;
        end
      end else if (tick) begin
        tmr <= end_cyc ? 16'h0000 : tmr + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // duty buffering and master phase hazard
  // ----------------------------------------
  logic [15:0] duty_act;
  logic        phase_bad;    // pending dead time loss at master boundary
  logic        skip_arm;     // boundary passed: the next edge loses dead time
  logic        lost;         // an edge was taken with no dead time
  // the boundary pulse rarely meets an edge, so the loss waits for the edge
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      duty_act  <= REG_ZERO;
      phase_bad <= 1'b0;
      skip_arm  <= 1'b0;
    end else begin
      if (imm_upd || (tick && end_cyc) || !module_on) begin
        duty_act <= duty;
      end
      if (wr_i && addr_i == PHASE_OFS && module_on && !itb && !imm_upd &&
          (wdata_i < dead || wdata_i > duty)) begin
        phase_bad <= 1'b1;
      end else if (master_period_i) begin
        phase_bad <= 1'b0;
      end
      // arming wins over the clear from a loss in the same cycle
      if (phase_bad && master_period_i) begin
        skip_arm <= 1'b1;
      end else if (lost) begin
        skip_arm <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // override synchronisation
  // ----------------------------------------
  // override_period_sync=0 applies next clock; override_period_sync=1 waits for the period boundary
  logic       ovr_on;        // both overrides applied
  logic [1:0] ovd_act;
  logic       rel_glitch, both_drop;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ovr_on     <= 1'b0;
      ovd_act    <= 2'h0;
      rel_glitch <= 1'b0;
      both_drop  <= 1'b0;
    end else begin
      rel_glitch <= 1'b0;
      both_drop  <= 1'b0;
      if (!override_period_sync || (tick && end_cyc)) begin
        ovr_on  <= ovr_h & ovr_l;
        ovd_act <= ovd;
        if (ovr_on && !(ovr_h & ovr_l) && module_on &&
            mode != MODE_REDUNDANT && mode != MODE_PUSHPULL) begin
          rel_glitch <= 1'b1;
          both_drop  <= !override_period_sync;
        end
      end
    end
  end

  // ----------------------------------------
  // pwm compare and output shaping
  // ----------------------------------------
  wire raw = (tmr >= phase) && (tmr < duty_act);
  logic hi_c, lo_c;
  pwg_deadtime u_dt (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .tick_i    (tick),
    .raw_i     (raw),
    .dead_i    (dead),
    .skip_dt_i (both_drop | skip_arm | (phase_bad & master_period_i)),
    .glitch_i  (rel_glitch),
    .hi_o      (hi_c),
    .lo_o      (lo_c),
    .lost_o    (lost)
  );

  // output mode and override mux
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      high_side_output_o <= 1'b0;
      low_side_output_o  <= 1'b0;
    end else if (!module_on) begin
      high_side_output_o <= 1'b0;
      low_side_output_o  <= 1'b0;
    end else if (ovr_on) begin
      high_side_output_o <= ovd_act[1];
      low_side_output_o  <= ovd_act[0];
    end else begin
      case (mode)
        MODE_REDUNDANT: begin
          high_side_output_o <= raw;
          low_side_output_o  <= raw;
        end
        MODE_PUSHPULL: begin
          high_side_output_o <= raw & ~alt;
          low_side_output_o  <= raw & alt;
        end
        default: begin
          high_side_output_o <= hi_c;
          low_side_output_o  <= lo_c;
        end
      endcase
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  assign ev = {lost, rel_glitch, rst_take, tick & end_cyc};
  // set wins over a write-one clear in the same cycle
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      irq_stat <= '0;
      irq_o    <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~((wr_i && addr_i == IRQ_STAT_OFS) ?
                   wdata_i[NUM_EVENTS-1:0] : '0)) | ev;
      irq_o    <= |(irq_stat & irq_mask);
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_off_outputs_low: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !$past(module_on) |-> !high_side_output_o && !low_side_output_o)
    else $error("outputs active while module off");
  a_ovr_full_duty: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $past(module_on && ovr_on && ovd_act == OVD_FULL_DUTY) |->
    high_side_output_o && !low_side_output_o)
    else $error("full duty override wrong");
  a_ovr_zero_duty: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $past(module_on && ovr_on && ovd_act == OVD_ZERO_DUTY) |->
    !high_side_output_o && low_side_output_o)
    else $error("zero duty override wrong");
  a_redundant_same: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $past(module_on && !ovr_on && mode == MODE_REDUNDANT) |->
    high_side_output_o == low_side_output_o)
    else $error("redundant outputs differ");
  a_itb_alt_reset: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (module_on && cur_rst && itb && cmp_rise && !alt) |=> tmr != 16'h0000 || $past(tmr) == 0)
    else $error("itb reset taken on odd cycle");
  a_override_period_sync_next_clk: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !override_period_sync |=> ovr_on == $past(ovr_h & ovr_l))
    else $error("override not applied next clock");
  a_tick_rate: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (div == 3'h0 && $past(div == 3'h0) && $past(div == 3'h0, 2) && $past(rst_n_i)) |-> tick)
    else $error("divider zero must tick each clock");
  a_phase_flag: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == PHASE_OFS && module_on && !itb && !imm_upd &&
     (wdata_i < dead || wdata_i > duty) && !master_period_i) |=> phase_bad)
    else $error("phase hazard not flagged");
  a_irq_level: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ##1 irq_o == |($past(irq_stat) & $past(irq_mask)))
    else $error("interrupt level wrong");

endmodule // pwg_core

// File: bench/pwg_stage_model.sv
// gate-driver and current-comparator model on the pin side of the pwm core
// assumes gate levels sampled on mclk_i; comparator lines idle low
`timescale 1ns/10ps
module pwg_stage_model (
  // clock and control
  input  wire logic        mclk_i,
  input  wire logic        clr_i,    // restart the statistics
  input  wire logic        fire_i,   // request one limit pulse
  input  wire logic [4:0]  sel_i,    // comparator line to pulse
  // gate inputs
  input  wire logic        hi_i,
  input  wire logic        lo_i,
  // comparator and statistics
  output logic      [31:0] cmp_o,
  output logic      [15:0] shoot_o,  // cycles with both gates on
  output logic      [15:0] gap_o     // shortest off gap before a rise
);
  logic [15:0] run;                  // length of the current both-off run
  logic        hp;                   // previous high gate
  logic        lp;                   // previous low gate

  initial cmp_o = 32'h0;

  // one-cycle pulse, 25 ns, stays under the 50 ns limit of divider code 001
  always @(posedge mclk_i) begin
    cmp_o <= fire_i ? (32'h1 << sel_i) : 32'h0;
  end

  // overlap counter and off-gap meter; a zero gap is caught on the rise
  always @(posedge mclk_i) begin
    hp <= hi_i;
    lp <= lo_i;
    if (clr_i) begin
      shoot_o <= 16'h0;
      gap_o   <= 16'hffff;
      run     <= 16'h00ff;
    end else begin
      if (hi_i && lo_i) shoot_o <= shoot_o + 16'h1;
      if ((hi_i && !hp) || (lo_i && !lp)) begin
        if (run < gap_o) gap_o <= run;
      end
      run <= (hi_i || lo_i) ? 16'h0 : run + 16'h1;
    end
  end
endmodule // pwg_stage_model

// File: bench/pwg_core_bench.sv
// self-checking bench for the complementary pwm generator core
// assumes pwg_pkg, pwg_core and the stage model are compiled first
`timescale 1ns/10ps
module pwg_core_bench;
  import pwg_pkg::*;

  // ----------------------------------------
  // stimulus and observation signals
  // ----------------------------------------
  logic        mclk_i          = 1'b0;
  logic        rst_n_i         = 1'b0;
  logic [3:0]  addr_i          = 4'h0;
  logic [15:0] wdata_i         = 16'h0;
  logic        wr_i            = 1'b0;
  logic        rd_i            = 1'b0;
  logic        master_period_i = 1'b0;
  logic        clr             = 1'b1;   // stage statistics held clear
  logic        fire            = 1'b0;
  logic [4:0]  sel             = 5'h0;
  logic        rd_q            = 1'b0;   // read data due this cycle
  logic        pchk            = 1'b0;   // pin check due this cycle
  logic [15:0] rdata_o;
  logic [15:0] shoot;
  logic [15:0] gap;
  logic [31:0] cmp_i;
  logic        high_side_output_o;
  logic        low_side_output_o;
  logic        irq_o;
  logic [31:0] rq[$];                    // pending reads {mask, value}
  logic [5:0]  pq[$];                    // pending pins {mask, irq hi lo}
  logic [31:0] e;
  logic [5:0]  p;
  int          errors  = 0;
  int          checked = 0;
  int          s;

  // 40 MHz clock
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end

  pwg_core dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cmp_i(cmp_i),
    .master_period_i(master_period_i), .high_side_output_o(high_side_output_o),
    .low_side_output_o(low_side_output_o), .irq_o(irq_o));

  pwg_stage_model stage (
    .mclk_i(mclk_i), .clr_i(clr), .fire_i(fire), .sel_i(sel),
    .hi_i(high_side_output_o), .lo_i(low_side_output_o), .cmp_o(cmp_i),
    .shoot_o(shoot), .gap_o(gap));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask

  // read: expectation noted now, compared when the data stand
  task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    rq.push_back({m, v});
    @(posedge mclk_i);
    rd_i   <= 1'b0;
  endtask

  task automatic pins(input logic [2:0] m, input logic [2:0] v);
    @(posedge mclk_i);
    pq.push_back({m, v});
    pchk <= 1'b1;
    @(posedge mclk_i);
    pchk <= 1'b0;
  endtask

  // one comparator pulse on the chosen line
  task automatic pulse(input logic [4:0] l);
    @(posedge mclk_i);
    sel  <= l;
    fire <= 1'b1;
    @(posedge mclk_i);
    fire <= 1'b0;
    repeat (10) @(posedge mclk_i);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // monitor: oldest note against what appears
  // ----------------------------------------
  always @(posedge mclk_i) rd_q <= rd_i;

  // falling edge: read data and pins have settled
  always @(negedge mclk_i) begin
    if (rd_q && rq.size() > 0) begin
      e = rq.pop_front();
      chk(rdata_o & e[31:16], e[15:0] & e[31:16]);
    end
    if (pchk && pq.size() > 0) begin
      p = pq.pop_front();
      chk({13'h0, p[5:3] & {irq_o, high_side_output_o, low_side_output_o}},
          {13'h0, p[5:3] & p[2:0]});
    end
  end

  // watchdog, far beyond the roughly 1500 cycles of the run
  initial begin
    #(25 * 20000);
    errors++;
    $display("timeout at %0t", $time);
    test_done();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(94));
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    // reset values; indices b..f are unmapped and read zero
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), 16'hffff, a == 3 ? PERIOD_RST : (a == 6 ? DEAD_RST : REG_ZERO));
    end
    wr(4'hb, 16'hffff);
    rd(4'hb, 16'hffff, REG_ZERO);
    repeat (4) begin
      s = $urandom;
      wr(PHASE_OFS, s[15:0]);
      rd(PHASE_OFS, 16'hffff, s[15:0]);
    end
    $display("test registers done");

    // both overrides on, clock-boundary sync: 01 low only, 10 high only
    wr(PHASE_OFS, 16'h0000);
    wr(DUTY_OFS, 16'h0080);
    wr(TB_CTRL_OFS, 16'h8000);
    for (int i = 1; i < 3; i++) begin
      wr(OUT_CTRL_OFS, 16'h0300 | 16'(i << OVD_LSB));
      repeat (3) @(posedge mclk_i);
      pins(3'h3, 3'(i));
    end
    $display("test override done");

    // release: event noted, then clean dead time with no overlap
    wr(IRQ_STAT_OFS, 16'hffff);
    wr(OUT_CTRL_OFS, 16'h0000);
    repeat (4) @(posedge mclk_i);
    rd(IRQ_STAT_OFS, 16'h0004, 16'h0004);
    repeat (8) @(posedge mclk_i);
    clr <= 1'b0;
    repeat (700) @(posedge mclk_i);
    chk(shoot, 16'h0);
    chk(16'(gap >= DEAD_RST), 16'h1);
    clr <= 1'b1;
    $display("test dead time done");

    // interrupt: masked, unmasked, cleared
    wr(IRQ_MASK_OFS, 16'h0000);
    wr(IRQ_STAT_OFS, 16'hffff);
    repeat (300) @(posedge mclk_i);
    rd(IRQ_STAT_OFS, 16'h0001, 16'h0001);
    pins(3'h4, 3'h0);
    wr(IRQ_MASK_OFS, 16'h0001);
    repeat (2) @(posedge mclk_i);
    pins(3'h4, 3'h4);
    wr(IRQ_MASK_OFS, 16'h0000);
    wr(IRQ_STAT_OFS, 16'hffff);
    repeat (2) @(posedge mclk_i);
    pins(3'h4, 3'h0);
    $display("test interrupt done");

    // master base phase write below dead time, then a master boundary
    wr(GEN_CTRL_OFS, 16'h0000);
    wr(IRQ_STAT_OFS, 16'hffff);
    wr(PHASE_OFS, 16'h0002);
    @(posedge mclk_i);
    master_period_i <= 1'b1;
    @(posedge mclk_i);
    master_period_i <= 1'b0;
    // the lost edge is the first one after the boundary, up to a period away
    repeat (300) @(posedge mclk_i);
    rd(IRQ_STAT_OFS, 16'h0008, 16'h0008);
    $display("test phase window done");

    // current reset from the selected comparator only
    wr(PHASE_OFS, 16'h0000);
    wr(TB_CTRL2_OFS, 16'h0001);
    s = $urandom_range(31);
    wr(FLT_CTRL_OFS, 16'(s << SRC_LSB));
    wr(GEN_CTRL_OFS, 16'h0202);
    wr(IRQ_STAT_OFS, 16'hffff);
    pulse(5'(s) ^ 5'h01);
    rd(IRQ_STAT_OFS, 16'h0002, 16'h0000);
    pulse(5'(s));
    rd(IRQ_STAT_OFS, 16'h0002, 16'h0000);
    pulse(5'(s));
    rd(IRQ_STAT_OFS, 16'h0002, 16'h0002);
    // host remedy: phase below duty, then at once the period
    wr(PHASE_OFS, 16'h0000);
    wr(PHASE_OFS, PERIOD_RST);
    rd(PHASE_OFS, 16'hffff, PERIOD_RST);
    $display("test current reset done");

    // output modes with the ideal level held high: redundant, push-pull, complementary
    wr(GEN_CTRL_OFS, 16'h0001);
    wr(PHASE_OFS, 16'h0000);
    wr(DUTY_OFS, 16'h0200);
    for (int m = 0; m < 3; m++) begin
      wr(OUT_CTRL_OFS, m == 0 ? 16'h0800 : (m == 1 ? 16'h0400 : 16'h0000));
      repeat (3) @(posedge mclk_i);
      pins(3'h3, m == 0 ? 3'h3 : 3'h2);
    end
    $display("test output modes done");
    repeat (5) @(posedge mclk_i);
    test_done();
  end
endmodule // pwg_core_bench
